// ===== hw/lev_defs.vh
// Register map, field positions and reset values of the limit-event output controller
`ifndef LEV_DEFS_VH
`define LEV_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define LEV_ADDR_CTRL       8'h00
`define LEV_ADDR_CLEAR      8'h04
`define LEV_ADDR_STATUS     8'h08
`define LEV_ADDR_IRQ_STAT   8'h0c
`define LEV_ADDR_IRQ_MASK   8'h10
`define LEV_ADDR_CH_REC     8'h14
`define LEV_ADDR_CHMAP_BASE 8'h40

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LEV_CTRL_MODE_LSB   0
`define LEV_CTRL_POL_LSB    4
`define LEV_STAT_ACT_LSB    0
`define LEV_STAT_PIN_LSB    4
`define LEV_STAT_REC_LSB    8
`define LEV_STAT_SCAN_BIT   12
`define LEV_CHMAP_EN_BIT    2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LEV_CTRL_RST        8'h0f
`define LEV_CHMAP_RST       3'h4
`define LEV_IRQ_MASK_RST    4'h0

// ----------------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------------
`define LEV_RESP_OKAY       2'h0
`define LEV_RESP_SLVERR     2'h2

`endif

// ===== hw/lev_line.v
// One limit-event line: latch or track behaviour, clears and output polarity
`timescale 1ns/1ps
`default_nettype none

module lev_line #(
  parameter IDLE_RST = 1'b1
) (
  input  wire clk,
  input  wire rst,
  input  wire latch_mode,
  input  wire pol_high,
  input  wire hit,
  input  wire outside,
  input  wire scan_start,
  input  wire clr,
  output wire active,
  output reg  pin_q
);

  reg  latch_q;
  reg  sup_q;
  reg  act_q;
  wire release_w;
  wire act_d;

  assign release_w = scan_start | clr;
  assign active    = act_q;

  // ----------------------------------------------------------------------------
  // Latched flag: a hit in the clearing cycle still wins
  // ----------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
      latch_q <= 1'b0;
    else if (hit)
      latch_q <= 1'b1;
    else if (release_w)
      latch_q <= 1'b0;
  end

  // ----------------------------------------------------------------------------
  // Track suppression: a clear holds the pin off until the reading returns inside
  // ----------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
      sup_q <= 1'b0;
    else if (release_w)
      sup_q <= 1'b1;
    else if (!outside)
      sup_q <= 1'b0;
  end

  assign act_d = latch_mode ? (hit | (latch_q & ~release_w))
                            : (outside & ~sup_q & ~release_w);

  // ----------------------------------------------------------------------------
  // Pin register
  // ----------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      act_q <= 1'b0;
      pin_q <= IDLE_RST;
    end
    else
    begin
      act_q <= act_d;
      pin_q <= pol_high ? act_d : ~act_d;
    end
  end

endmodule // lev_line

`default_nettype wire

// ===== hw/lev_alarm_ctrl.v
// Four-line limit-event output controller with AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lev_defs.vh"

module lev_alarm_ctrl #(
  parameter NUM_CH = 32,
  parameter ADDR_W = 8
) (
  input  wire              clk,
  input  wire              rst,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              scan_start,
  input  wire              scan_active,
  input  wire [NUM_CH-1:0] ch_event,
  input  wire [NUM_CH-1:0] ch_outside,
  output wire              limit_event_line_1,
  output wire              limit_event_line_2,
  output wire              limit_event_line_3,
  output wire              limit_event_line_4,
  output wire              irq
);

  localparam NUM_LINES = 4;
  localparam [ADDR_W-1:0] CH_CNT = NUM_CH;
  localparam [2:0]        MAP_RST  = `LEV_CHMAP_RST;
  localparam [7:0]        CTRL_RST = `LEV_CTRL_RST;

  // ----------------------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------------------
  reg               aw_q;
  reg  [ADDR_W-1:0] awaddr_q;
  reg               w_q;
  reg  [31:0]       wdata_q;
  reg  [3:0]        wstrb_q;
  wire              wr_en;
  wire [31:0]       wmask;

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign wr_en         = aw_q && w_q;
  assign wmask         = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always @(posedge clk)
  begin
    if (rst)
    begin
      aw_q     <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      w_q      <= 1'b0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_en)
        aw_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (wr_en)
        w_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Write address decode
  // ----------------------------------------------------------------------------
  wire [ADDR_W-1:0] w_off;
  wire [ADDR_W-3:0] w_idx;
  wire              w_in_map;
  reg               wr_ctrl;
  reg               wr_clear;
  reg               wr_istat;
  reg               wr_imask;
  reg               wr_map;
  reg               wr_ok;

  assign w_off    = awaddr_q - `LEV_ADDR_CHMAP_BASE;
  assign w_idx    = w_off[ADDR_W-1:2];
  assign w_in_map = (awaddr_q >= `LEV_ADDR_CHMAP_BASE) && (w_off < {CH_CNT[ADDR_W-3:0], 2'b00});

  always @*
  begin
    wr_ctrl  = 1'b0;
    wr_clear = 1'b0;
    wr_istat = 1'b0;
    wr_imask = 1'b0;
    wr_map   = 1'b0;
    wr_ok    = 1'b1;
    if (awaddr_q == `LEV_ADDR_CTRL)
      wr_ctrl = wr_en;
    else if (awaddr_q == `LEV_ADDR_CLEAR)
      wr_clear = wr_en;
    else if (awaddr_q == `LEV_ADDR_IRQ_STAT)
      wr_istat = wr_en;
    else if (awaddr_q == `LEV_ADDR_IRQ_MASK)
      wr_imask = wr_en;
    else if (w_in_map)
      wr_map = wr_en;
    else if (awaddr_q == `LEV_ADDR_STATUS || awaddr_q == `LEV_ADDR_CH_REC)
      wr_ok = 1'b1;
    else
      wr_ok = 1'b0;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LEV_RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `LEV_RESP_OKAY : `LEV_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------------------
  // Control, mask and manual clear
  // ----------------------------------------------------------------------------
  reg  [7:0] ctrl_q;
  reg  [3:0] imask_q;
  wire [7:0] ctrl_d;
  wire [3:0] mode_latch;
  wire [3:0] pol_high;
  wire [3:0] clr_pulse;

  assign ctrl_d     = (ctrl_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
  assign mode_latch = ctrl_q[`LEV_CTRL_MODE_LSB+3:`LEV_CTRL_MODE_LSB];
  assign pol_high   = ctrl_q[`LEV_CTRL_POL_LSB+3:`LEV_CTRL_POL_LSB];
  // Clear is a command, not storage; it reads back as zero
  assign clr_pulse  = wr_clear ? (wdata_q[3:0] & wmask[3:0]) : 4'h0;

  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q  <= `LEV_CTRL_RST;
      imask_q <= `LEV_IRQ_MASK_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= ctrl_d;
      if (wr_imask && wstrb_q[0])
        imask_q <= wdata_q[3:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Channel to line map
  // ----------------------------------------------------------------------------
  reg  [1:0]              line_sel_q [0:NUM_CH-1];
  reg  [NUM_CH-1:0]       en_q;
  wire [NUM_LINES*NUM_CH-1:0] member;

  genvar gi;
  genvar gl;
  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1)
    begin : g_ch
      always @(posedge clk)
      begin
        if (rst)
        begin
          line_sel_q[gi] <= MAP_RST[1:0];
          en_q[gi]       <= MAP_RST[`LEV_CHMAP_EN_BIT];
        end
        else if (wr_map && wstrb_q[0] && w_idx == gi)
        begin
          // Enable set adds the channel, enable clear deletes it
          line_sel_q[gi] <= wdata_q[1:0];
          en_q[gi]       <= wdata_q[`LEV_CHMAP_EN_BIT];
        end
      end
      for (gl = 0; gl < NUM_LINES; gl = gl + 1)
      begin : g_mem
        assign member[gl*NUM_CH+gi] = en_q[gi] && (line_sel_q[gi] == gl);
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Per-line combining and output stage
  // ----------------------------------------------------------------------------
  wire [NUM_LINES-1:0] line_hit;
  wire [NUM_LINES-1:0] line_out;
  wire [NUM_LINES-1:0] line_act;
  wire [NUM_LINES-1:0] pin;

  generate
    for (gl = 0; gl < NUM_LINES; gl = gl + 1)
    begin : g_line
      // Readings only count while a scan or monitor session runs
      assign line_hit[gl] = scan_active && |(ch_event & member[gl*NUM_CH +: NUM_CH]);
      assign line_out[gl] = scan_active && |(ch_outside & member[gl*NUM_CH +: NUM_CH]);

      lev_line #(
        .IDLE_RST (~CTRL_RST[`LEV_CTRL_POL_LSB + gl])
      ) u_line (
        .clk        (clk),
        .rst        (rst),
        .latch_mode (mode_latch[gl]),
        .pol_high   (pol_high[gl]),
        .hit        (line_hit[gl]),
        .outside    (line_out[gl]),
        .scan_start (scan_start),
        .clr        (clr_pulse[gl]),
        .active     (line_act[gl]),
        .pin_q      (pin[gl])
      );
    end
  endgenerate

  assign limit_event_line_1 = pin[0];
  assign limit_event_line_2 = pin[1];
  assign limit_event_line_3 = pin[2];
  assign limit_event_line_4 = pin[3];

  // ----------------------------------------------------------------------------
  // Event records: kept by manual clear, erased by a new scan
  // ----------------------------------------------------------------------------
  reg [NUM_CH-1:0]    ch_rec_q;
  reg [NUM_LINES-1:0] line_rec_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      ch_rec_q   <= {NUM_CH{1'b0}};
      line_rec_q <= 4'h0;
    end
    else if (scan_start)
    begin
      // An event in the start cycle belongs to the new scan
      ch_rec_q   <= ch_event & {NUM_CH{scan_active}};
      line_rec_q <= line_hit;
    end
    else
    begin
      ch_rec_q   <= ch_rec_q | (ch_event & {NUM_CH{scan_active}});
      line_rec_q <= line_rec_q | line_hit;
    end
  end

  // ----------------------------------------------------------------------------
  // Interrupt status, write one to clear, set wins
  // ----------------------------------------------------------------------------
  reg  [3:0] istat_q;
  wire [3:0] istat_clr;

  assign istat_clr = wr_istat ? (wdata_q[3:0] & wmask[3:0]) : 4'h0;
  assign irq       = |(istat_q & imask_q);

  always @(posedge clk)
  begin
    if (rst)
      istat_q <= 4'h0;
    else
      istat_q <= (istat_q & ~istat_clr) | line_hit;
  end

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  wire [ADDR_W-1:0] r_off;
  wire [ADDR_W-3:0] r_idx;
  wire              r_in_map;
  reg  [31:0]       rd_data;
  reg               rd_ok;
  integer           k;

  assign s_axi_arready = !s_axi_rvalid;
  assign r_off         = s_axi_araddr - `LEV_ADDR_CHMAP_BASE;
  assign r_idx         = r_off[ADDR_W-1:2];
  assign r_in_map      = (s_axi_araddr >= `LEV_ADDR_CHMAP_BASE) && (r_off < {CH_CNT[ADDR_W-3:0], 2'b00});

  always @*
  begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    if (s_axi_araddr == `LEV_ADDR_CTRL)
      rd_data[7:0] = ctrl_q;
    else if (s_axi_araddr == `LEV_ADDR_CLEAR)
      rd_data = 32'h00000000;
    else if (s_axi_araddr == `LEV_ADDR_STATUS)
    begin
      rd_data[`LEV_STAT_ACT_LSB+3:`LEV_STAT_ACT_LSB] = line_act;
      rd_data[`LEV_STAT_PIN_LSB+3:`LEV_STAT_PIN_LSB] = pin;
      rd_data[`LEV_STAT_REC_LSB+3:`LEV_STAT_REC_LSB] = line_rec_q;
      rd_data[`LEV_STAT_SCAN_BIT]                    = scan_active;
    end
    else if (s_axi_araddr == `LEV_ADDR_IRQ_STAT)
      rd_data[3:0] = istat_q;
    else if (s_axi_araddr == `LEV_ADDR_IRQ_MASK)
      rd_data[3:0] = imask_q;
    else if (s_axi_araddr == `LEV_ADDR_CH_REC)
    begin
      for (k = 0; k < NUM_CH && k < 32; k = k + 1)
        rd_data[k] = ch_rec_q[k];
    end
    else if (r_in_map)
    begin
      for (k = 0; k < NUM_CH; k = k + 1)
      begin
        if (r_idx == k)
        begin
          rd_data[1:0]                = line_sel_q[k];
          rd_data[`LEV_CHMAP_EN_BIT] = en_q[k];
        end
      end
    end
    else
      rd_ok = 1'b0;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `LEV_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_ok ? `LEV_RESP_OKAY : `LEV_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // lev_alarm_ctrl

`default_nettype wire

// ===== dv/lev_pin_mon.sv
// Passive model of the equipment that watches the four alarm pins
`timescale 1ns/1ps
`default_nettype none
module lev_pin_mon (
  input  wire logic       clk,
  input  wire logic [3:0] pins,
  output var  logic [3:0] seen_q
);
  // The far side only listens, so a registered sample is all it keeps
  always @(posedge clk) seen_q <= pins;
endmodule // lev_pin_mon
`default_nettype wire

// ===== dv/lev_alarm_ctrl_sva.sv
// Bus and pin assertions for the limit-event output controller
`timescale 1ns/1ps
`default_nettype none
module lev_alarm_ctrl_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        scan_start,
  input wire logic        scan_active,
  input wire logic        limit_event_line_1,
  input wire logic        limit_event_line_2,
  input wire logic        limit_event_line_3,
  input wire logic        limit_event_line_4,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [3:0] pins;
  assign pins = {limit_event_line_4, limit_event_line_3, limit_event_line_2, limit_event_line_1};
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready while data pending");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  chk_reset_idle: assert property ($fell(rst) |-> pins == 4'hf && !irq)
    else $error("pins not idle after reset");
  // Pins may only move on scan activity or a register write
  chk_pins_quiet: assert property (!scan_active && !scan_start && !$past(scan_active)
    && !$past(scan_start) && !$past(s_axi_awvalid) && !$past(s_axi_wvalid) |=> $stable(pins))
    else $error("pin moved while idle");
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
  cov_line1: cover property ($fell(limit_event_line_1));
  cov_irq: cover property ($rose(irq));
endmodule // lev_alarm_ctrl_sva
bind lev_alarm_ctrl lev_alarm_ctrl_sva i_sva (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .scan_start, .scan_active, .limit_event_line_1, .limit_event_line_2,
  .limit_event_line_3, .limit_event_line_4, .irq);
`default_nettype wire

// ===== dv/lev_alarm_ctrl_tb_top.sv
// Self-checking bench for the limit-event output controller
`timescale 1ns/1ps
`default_nettype none
`include "lev_defs.vh"
module lev_alarm_ctrl_tb_top;
  logic        clk, rst, scan_start, scan_active;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, ch_event, ch_outside, rd;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [3:0]  pins, seen;
  logic [1:0]  rsp;
  logic [15:0] lfsr_q;
  logic [4:0]  ca, cb, cc;
  int          n_mismatch, total_checks;

  lev_alarm_ctrl i_dut (
    .clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scan_start, .scan_active,
    .ch_event, .ch_outside, .limit_event_line_1(pins[0]), .limit_event_line_2(pins[1]),
    .limit_event_line_3(pins[2]), .limit_event_line_4(pins[3]), .irq);
  lev_pin_mon i_mon (.clk, .pins, .seen_q(seen));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------------------
  // Idle level is the inverse of the chosen active level
  function automatic logic [3:0] lvl(input logic [3:0] act, input logic [3:0] pol);
    return (act & pol) | (~act & ~pol);
  endfunction
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic report_and_stop;
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo;
    chk("handshake", 32'h1, 32'h0);
    report_and_stop();
  endtask
  task automatic pchk(input logic [3:0] e);
    chk("pins", {28'h0, e}, {28'h0, seen});
  endtask
  task automatic ichk(input logic e);
    @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // ----------------------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb, hv;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Ready early on some registers and late on others, so the hold checks see a stall
    s_axi_bready <= ~a[2];
    repeat (50)
    begin
      @(negedge clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hv = s_axi_bvalid;
      hb = hv && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb)
      begin
        s_axi_bready <= 1'b0;
        return;
      end
      if (hv) s_axi_bready <= 1'b1;
    end
    tmo();
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr, hv;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= ~a[2];
    repeat (50)
    begin
      @(negedge clk);
      ha = s_axi_arvalid && s_axi_arready;
      hv = s_axi_rvalid;
      hr = hv && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr)
      begin
        s_axi_rready <= 1'b0;
        return;
      end
      if (hv) s_axi_rready <= 1'b1;
    end
    tmo();
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rsp);
    chk("bresp", 32'h0, {30'h0, rsp});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    rd_reg(a, rd, rsp);
    chk(nm, e, rd & m);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse(input logic [4:0] c);
    @(posedge clk);
    ch_event[c] <= 1'b1;
    @(posedge clk);
    ch_event <= 32'h0;
    settle();
  endtask
  task automatic sstart;
    @(posedge clk);
    scan_start <= 1'b1;
    @(posedge clk);
    scan_start <= 1'b0;
    settle();
  endtask
  function automatic logic [7:0] map_a(input logic [4:0] c);
    return `LEV_ADDR_CHMAP_BASE + {1'b0, c, 2'b00};
  endfunction

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    {scan_start, scan_active, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ch_event, ch_outside} = 112'h0;
    s_axi_wstrb = 4'hf;
    lfsr_q = 16'h14f5;
    n_mismatch = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    pchk(4'hf);
    rchk(`LEV_ADDR_CTRL, 32'hff, 32'h0f, "ctrl");
    rchk(`LEV_ADDR_IRQ_MASK, 32'hf, 32'h0, "mask");
    repeat (4)
    begin
      lfsr_q = nxt(lfsr_q);
      rchk(map_a(lfsr_q[4:0]), 32'h7, 32'h4, "chmap");
    end
    ca = lfsr_q[9:5];
    cb = ca ^ 5'h1;
    cc = ca ^ 5'h2;
    rd_reg(8'h20, rd, rsp);
    chk("rresp", 32'h2, {30'h0, rsp});
    chk("rdata", 32'h0, rd);
    wr(8'hfc, 32'h1, rsp);
    chk("bresp", 32'h2, {30'h0, rsp});
    // Latched line with clears
    @(posedge clk);
    scan_active <= 1'b1;
    sstart();
    pulse(cc);
    pchk(lvl(4'h1, 4'h0));
    settle();
    pchk(lvl(4'h1, 4'h0));
    rchk(`LEV_ADDR_STATUS, 32'hf00, 32'h100, "record");
    w(`LEV_ADDR_CLEAR, 32'h1);
    settle();
    pchk(4'hf);
    rchk(`LEV_ADDR_CH_REC, 32'h1 << cc, 32'h1 << cc, "chrec");
    pulse(cc);
    pchk(lvl(4'h1, 4'h0));
    sstart();
    pchk(4'hf);
    rchk(`LEV_ADDR_CH_REC, 32'hffffffff, 32'h0, "chrec");
    @(posedge clk);
    scan_active <= 1'b0;
    pulse(cc);
    pchk(4'hf);
    @(posedge clk);
    scan_active <= 1'b1;
    // Membership of each line
    for (int l = 0; l < 4; l++)
    begin
      w(map_a(ca), 32'(4 + l));
      pulse(ca);
      pchk(lvl(4'h1 << l, 4'h0));
      w(`LEV_ADDR_CLEAR, 32'hf);
      settle();
      pchk(4'hf);
    end
    w(map_a(cb), 32'h7);
    pulse(cb);
    pchk(lvl(4'h8, 4'h0));
    w(map_a(cb), 32'h0);
    w(`LEV_ADDR_CLEAR, 32'hf);
    pulse(cb);
    pchk(4'hf);
    // Polarity, then tracking on line 1
    w(`LEV_ADDR_CTRL, 32'hff);
    settle();
    pchk(4'h0);
    pulse(cc);
    pchk(4'h1);
    w(`LEV_ADDR_CLEAR, 32'hf);
    repeat (3)
    begin
      lfsr_q = nxt(lfsr_q);
      w(`LEV_ADDR_CTRL, {24'h0, lfsr_q[3:0], 4'hf});
      settle();
      pchk(lvl(4'h0, lfsr_q[3:0]));
    end
    w(`LEV_ADDR_CTRL, 32'h1e);
    @(posedge clk);
    ch_outside[cc] <= 1'b1;
    settle();
    pchk(lvl(4'h1, 4'h1));
    @(posedge clk);
    ch_outside <= 32'h0;
    settle();
    pchk(lvl(4'h0, 4'h1));
    @(posedge clk);
    ch_outside[cc] <= 1'b1;
    sstart();
    pchk(lvl(4'h0, 4'h1));
    @(posedge clk);
    ch_outside <= 32'h0;
    // Interrupt raise, mask and clear
    w(`LEV_ADDR_CTRL, 32'h0f);
    w(`LEV_ADDR_IRQ_STAT, 32'hf);
    rchk(`LEV_ADDR_IRQ_STAT, 32'hf, 32'h0, "irqst");
    w(`LEV_ADDR_IRQ_MASK, 32'h1);
    ichk(1'b0);
    pulse(cc);
    ichk(1'b1);
    rchk(`LEV_ADDR_IRQ_STAT, 32'hf, 32'h1, "irqst");
    w(`LEV_ADDR_IRQ_MASK, 32'h0);
    ichk(1'b0);
    w(`LEV_ADDR_IRQ_MASK, 32'h1);
    ichk(1'b1);
    w(`LEV_ADDR_IRQ_STAT, 32'h1);
    ichk(1'b0);
    report_and_stop();
  end
endmodule // lev_alarm_ctrl_tb_top
`default_nettype wire
